// ==== shared/line_uart_map.svh ====
/*
  Bit positions, reset values and timing figures of the multi-octet link block.
  Assumes a 100 MHz ref_clk; included by bare name.
*/
`ifndef LINE_UART_MAP_SVH
`define LINE_UART_MAP_SVH

// ----------------------------------------------------------------------------
// status byte layout
// ----------------------------------------------------------------------------
`define STAT_DATA_EVENT 0
`define STAT_INT 1
`define STAT_RX_ERROR 2
`define STAT_SHORT 3
`define STAT_UNDER_VOLT 4
`define STAT_OVER_TEMP 5

// ----------------------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------------------
`define FRAME_COUNT 15
`define IDX_ZERO 4'h0
`define IDX_ONE 4'h1
`define OCTET_ZERO 8'h00
`define SYNC_ZERO 3'h0
`define RST_SYNC_ZERO 2'h0
`define RST_SYNC_ONE 2'h1

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define EVENT_CLEAR_NS 220
`define EVENT_CLEAR_CYCLES (`EVENT_CLEAR_NS / `CLK_PERIOD_NS)
`define RESTART_CYCLES_DEFAULT 100000

`endif

// ==== shared/line_uart_pkg.sv ====
/*
  Types of the multi-octet link block: link states and signal bundles.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package line_uart_pkg;

  typedef enum logic [3:0]
  {
    OUTPUT_ACTIVE_STATE = 4'h1,
    WAKEUP_LISTEN_STATE = 4'h2,
    COMM_LISTEN_STATE = 4'h4,
    TRANSMIT_STATE = 4'h8
  } link_state_e;

  typedef struct packed
  {
    logic shortCircuit;
    logic underVoltage;
    logic overTemp;
  } fault_s;

  typedef struct packed
  {
    logic valid;
    logic msgDone;
    logic error;
    logic busy;
    logic [7:0] octet;
  } rx_s;

endpackage

// ==== core/line_uart_multi_octet_link_fsm.sv ====
/*
  Multi-octet link state machine with its transmit FIFO.
  Assumes a line decoder and transmitter on ref_clk, and an SPI front end that
  turns accesses and commands into one-cycle pulses on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "line_uart_map.svh"

module line_uart_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } fifo_state_s;

  fifo_state_s q;
  fifo_state_s next_q;
  logic push;
  logic pop;

  always_comb
  begin
    inReady = (q.count != (AW+1)'(DEPTH));
    outValid = (q.count != '0);
    outData = q.mem[q.rdPtr];
    push = inValid && inReady;
    pop = outValid && outReady;
    next_q = q;
    if (push)
    begin
      next_q.mem[q.wrPtr] = inData;
      next_q.wrPtr = q.wrPtr + AW'(1);
    end
    if (pop)
    begin
      next_q.rdPtr = q.rdPtr + AW'(1);
    end
    next_q.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      next_q.wrPtr = '0;
      next_q.rdPtr = '0;
      next_q.count = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule

module line_uart_multi_octet_link_fsm #(
  parameter int RESTART_CYCLES = `RESTART_CYCLES_DEFAULT,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic switchOutputModeBit,
  input wire logic highSideEnable,
  input wire logic lowSideEnable,
  input wire logic wakeupPin,
  input wire line_uart_pkg::fault_s faultPins,
  input wire line_uart_pkg::rx_s rxIn,
  input wire logic statusAccess,
  input wire logic cmdEnd,
  input wire logic cmdSend,
  input wire logic [3:0] txLength,
  input wire logic bufWrEn,
  input wire logic [3:0] bufWrAddr,
  input wire logic [7:0] bufWrData,
  input wire logic [3:0] bufRdAddr,
  input wire logic txReady,
  input wire logic txIdle,
  output logic lineHigh,
  output logic lineLow,
  output logic rxEnable,
  output logic rxReset,
  output logic intPin,
  output logic [7:0] statusByte,
  output line_uart_pkg::link_state_e linkState,
  output logic [7:0] bufRdData,
  output logic txValid,
  output logic [7:0] txOctet,
  output logic restartRunning
);

  // --------------------------------------------------------------------------
  // state record
  // --------------------------------------------------------------------------
  typedef struct packed
  {
    line_uart_pkg::link_state_e state;
    logic [2:0] wakeSync;
    logic wakeFilt;
    logic [2:0] scSync;
    logic [2:0] uvSync;
    logic [2:0] otSync;
    line_uart_pkg::fault_s faults;
    line_uart_pkg::fault_s reported;
    logic [`FRAME_COUNT-1:0][7:0] frames;
    logic [3:0] rxIdx;
    logic [3:0] txIdx;
    logic sending;
    logic dataEvent;
    logic waitHalt;
    logic rxErrorFlag;
    logic shortFlag;
    logic [31:0] restartCnt;
    logic lineHigh;
    logic lineLow;
    logic rxEnable;
    logic rxReset;
    logic intPin;
    logic [7:0] statusByte;
    logic [7:0] bufRdData;
    logic txValid;
    logic [7:0] txOctet;
    logic restartRunning;
  } link_state_s;

  link_state_s q;
  link_state_s next_q;
  logic [1:0] rstSync;
  logic rst_n;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [7:0] fifoOutData;
  logic fifoFlush;

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync <= `RST_SYNC_ZERO;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rst_n = rstSync[1];

  line_uart_tx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) txFifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(fifoFlush),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(q.frames[q.txIdx]),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic listenMode;
    logic wakeArmed;
    logic faultOff;
    logic txFinished;
    logic statusChange;
    listenMode = 1'b0;
    wakeArmed = 1'b0;
    faultOff = 1'b0;
    txFinished = 1'b0;
    statusChange = 1'b0;
    next_q = q;
    // three-stage pin synchronisers; a change counts once stages two and three agree
    next_q.wakeSync = {q.wakeSync[1:0], wakeupPin};
    next_q.scSync = {q.scSync[1:0], faultPins.shortCircuit};
    next_q.uvSync = {q.uvSync[1:0], faultPins.underVoltage};
    next_q.otSync = {q.otSync[1:0], faultPins.overTemp};
    if (q.wakeSync[1] == q.wakeSync[2])
      next_q.wakeFilt = q.wakeSync[2];
    if (q.scSync[1] == q.scSync[2])
      next_q.faults.shortCircuit = q.scSync[2];
    if (q.uvSync[1] == q.uvSync[2])
      next_q.faults.underVoltage = q.uvSync[2];
    if (q.otSync[1] == q.otSync[2])
      next_q.faults.overTemp = q.otSync[2];

    wakeArmed = highSideEnable ^ lowSideEnable;
    faultOff = q.faults.shortCircuit || q.faults.overTemp;
    txFinished = q.sending && (q.txIdx == txLength) && !fifoOutValid && !q.txValid && txIdle;
    fifoInValid = (q.state == line_uart_pkg::TRANSMIT_STATE) && q.sending
      && (q.txIdx != txLength);
    fifoOutReady = !q.txValid || txReady;
    fifoFlush = 1'b0;
    next_q.rxReset = 1'b0;

    if (fifoInValid && fifoInReady)
      next_q.txIdx = q.txIdx + `IDX_ONE;
    if (fifoOutReady)
    begin
      next_q.txValid = fifoOutValid;
      next_q.txOctet = fifoOutData;
    end

    // buffers stay open to the host in every state, the wait included
    if (bufWrEn && (bufWrAddr < 4'(`FRAME_COUNT)))
      next_q.frames[bufWrAddr] = bufWrData;
    next_q.bufRdData = (bufRdAddr < 4'(`FRAME_COUNT)) ? q.frames[bufRdAddr] : `OCTET_ZERO;

    case (q.state)
      line_uart_pkg::OUTPUT_ACTIVE_STATE:
      begin
        if (!switchOutputModeBit)
        begin
          next_q.state = line_uart_pkg::COMM_LISTEN_STATE;
          next_q.rxIdx = `IDX_ZERO;
        end
        else if (wakeArmed && q.wakeFilt)
        begin
          next_q.state = line_uart_pkg::WAKEUP_LISTEN_STATE;
          next_q.restartCnt = '0;
          next_q.rxIdx = `IDX_ZERO;
        end
      end
      line_uart_pkg::WAKEUP_LISTEN_STATE:
      begin
        listenMode = 1'b1;
        next_q.restartCnt = q.restartCnt + 32'h00000001;
        if (!switchOutputModeBit)
          next_q.state = line_uart_pkg::COMM_LISTEN_STATE;
        else if (rxIn.msgDone && !rxIn.error)
        begin
          next_q.state = line_uart_pkg::TRANSMIT_STATE;
          next_q.dataEvent = 1'b1;
          next_q.rxErrorFlag = 1'b0;
          next_q.restartCnt = '0;
        end
        else if (rxIn.msgDone)
          next_q.rxIdx = `IDX_ZERO;
        else if (q.restartCnt >= 32'(RESTART_CYCLES - 1))
          next_q.state = line_uart_pkg::OUTPUT_ACTIVE_STATE;
      end
      line_uart_pkg::COMM_LISTEN_STATE:
      begin
        listenMode = 1'b1;
        if (switchOutputModeBit)
        begin
          next_q.state = line_uart_pkg::OUTPUT_ACTIVE_STATE;
          next_q.rxReset = rxIn.busy;
          next_q.rxIdx = `IDX_ZERO;
        end
        else if (rxIn.msgDone || rxIn.error)
        begin
          next_q.state = line_uart_pkg::TRANSMIT_STATE;
          next_q.dataEvent = 1'b1;
          next_q.rxErrorFlag = rxIn.error;
        end
      end
      line_uart_pkg::TRANSMIT_STATE:
      begin
        if (cmdSend && !q.sending)
        begin
          next_q.sending = 1'b1;
          next_q.txIdx = `IDX_ZERO;
        end
        if (q.faults.shortCircuit)
        begin
          next_q.shortFlag = 1'b1;
          next_q.state = switchOutputModeBit ? line_uart_pkg::WAKEUP_LISTEN_STATE
            : line_uart_pkg::COMM_LISTEN_STATE;
          next_q.restartCnt = '0;
        end
        else if (cmdEnd || txFinished)
          next_q.state = switchOutputModeBit ? line_uart_pkg::OUTPUT_ACTIVE_STATE
            : line_uart_pkg::COMM_LISTEN_STATE;
        if (next_q.state != line_uart_pkg::TRANSMIT_STATE)
        begin
          next_q.sending = 1'b0;
          next_q.rxIdx = `IDX_ZERO;
          next_q.txValid = 1'b0;
          fifoFlush = 1'b1;
        end
      end
      default:
      begin
        next_q.state = line_uart_pkg::COMM_LISTEN_STATE;
      end
    endcase

    // received octets fill the frame buffers in both listen states
    if (listenMode && rxIn.valid && (q.rxIdx < 4'(`FRAME_COUNT)))
    begin
      next_q.frames[q.rxIdx] = rxIn.octet;
      next_q.rxIdx = q.rxIdx + `IDX_ONE;
    end

    // data-event handshake with the host
    if (statusAccess && q.dataEvent)
      next_q.waitHalt = 1'b1;
    if ((cmdEnd || cmdSend) && q.state == line_uart_pkg::TRANSMIT_STATE)
    begin
      next_q.dataEvent = 1'b0;
      next_q.waitHalt = 1'b0;
    end

    // an access reports current faults, so it retires the change interrupt
    if (statusAccess)
    begin
      next_q.reported = q.faults;
      next_q.shortFlag = q.faults.shortCircuit;
    end
    if (q.faults.shortCircuit && q.state == line_uart_pkg::TRANSMIT_STATE)
      next_q.shortFlag = 1'b1;
    statusChange = (next_q.reported != q.faults);

    next_q.intPin = next_q.dataEvent || next_q.waitHalt || statusChange;
    next_q.statusByte = `OCTET_ZERO;
    next_q.statusByte[`STAT_DATA_EVENT] = next_q.dataEvent;
    next_q.statusByte[`STAT_INT] = next_q.intPin;
    next_q.statusByte[`STAT_RX_ERROR] = next_q.rxErrorFlag;
    next_q.statusByte[`STAT_SHORT] = next_q.shortFlag;
    next_q.statusByte[`STAT_UNDER_VOLT] = q.faults.underVoltage;
    next_q.statusByte[`STAT_OVER_TEMP] = q.faults.overTemp;

    next_q.lineHigh = (next_q.state == line_uart_pkg::OUTPUT_ACTIVE_STATE) && wakeArmed
      && highSideEnable && !faultOff;
    next_q.lineLow = (next_q.state == line_uart_pkg::OUTPUT_ACTIVE_STATE) && wakeArmed
      && lowSideEnable && !faultOff;
    next_q.rxEnable = (next_q.state == line_uart_pkg::WAKEUP_LISTEN_STATE)
      || (next_q.state == line_uart_pkg::COMM_LISTEN_STATE);
    next_q.restartRunning = (next_q.state == line_uart_pkg::WAKEUP_LISTEN_STATE);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.state <= line_uart_pkg::COMM_LISTEN_STATE;
      q.rxEnable <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign lineHigh = q.lineHigh;
  assign lineLow = q.lineLow;
  assign rxEnable = q.rxEnable;
  assign rxReset = q.rxReset;
  assign intPin = q.intPin;
  assign statusByte = q.statusByte;
  assign linkState = q.state;
  assign bufRdData = q.bufRdData;
  assign txValid = q.txValid;
  assign txOctet = q.txOctet;
  assign restartRunning = q.restartRunning;

endmodule
`default_nettype wire

// ==== bench/line_link_checker.sv ====
/*
  Assertion checker of the multi-octet link block, bound to its top module.
  Assumes one clock ref_clk and arst_n active low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "line_uart_map.svh"

module line_link_checker #(
  parameter int RESTART_CYCLES = 50
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic switchOutputModeBit,
  input wire line_uart_pkg::fault_s faultPins,
  input wire line_uart_pkg::rx_s rxIn,
  input wire logic statusAccess,
  input wire logic cmdEnd,
  input wire logic cmdSend,
  input wire logic lineHigh,
  input wire logic lineLow,
  input wire logic rxEnable,
  input wire logic rxReset,
  input wire logic intPin,
  input wire logic [7:0] statusByte,
  input wire line_uart_pkg::link_state_e linkState,
  input wire logic restartRunning
);
  int wakeCnt;
  int quietCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // --------
  // helper counters
  // --------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wakeCnt <= 0;
      quietCnt <= 0;
    end
    else
    begin
      wakeCnt <= (linkState == line_uart_pkg::WAKEUP_LISTEN_STATE) ? wakeCnt + 1 : 0;
      quietCnt <= $stable(faultPins) ? quietCnt + 1 : 0;
    end
  end
  sequence s_msg_in(st);
    linkState == st && rxIn.msgDone && !rxIn.error;
  endsequence
  sequence s_halted;
    statusByte[`STAT_DATA_EVENT] && !cmdEnd && !cmdSend;
  endsequence
  property p_int_mirror;
    intPin == statusByte[`STAT_INT];
  endproperty
  a_int_mirror: assert property (p_int_mirror) else $error("int pin and bit differ");
  property p_comm_msg;
    s_msg_in(line_uart_pkg::COMM_LISTEN_STATE) |=>
      linkState == line_uart_pkg::TRANSMIT_STATE && statusByte[`STAT_DATA_EVENT];
  endproperty
  a_comm_msg: assert property (p_comm_msg) else $error("no transmit after message");
  property p_wake_msg;
    s_msg_in(line_uart_pkg::WAKEUP_LISTEN_STATE) |=>
      linkState == line_uart_pkg::TRANSMIT_STATE && intPin && !restartRunning;
  endproperty
  a_wake_msg: assert property (p_wake_msg) else $error("wake message not taken");
  property p_halt;
    s_halted |=> statusByte[`STAT_DATA_EVENT] && intPin;
  endproperty
  a_halt: assert property (p_halt) else $error("data event dropped in wait");
  property p_cmd_clear;
    statusByte[`STAT_DATA_EVENT] && (cmdEnd || cmdSend) |=> !statusByte[`STAT_DATA_EVENT];
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("data event not cleared");
  property p_wake_off;
    linkState == line_uart_pkg::WAKEUP_LISTEN_STATE &&
      $past(linkState) == line_uart_pkg::WAKEUP_LISTEN_STATE |-> !lineHigh && !lineLow;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("line driven in wake listen");
  property p_active_rx;
    linkState == line_uart_pkg::OUTPUT_ACTIVE_STATE &&
      $past(linkState) == line_uart_pkg::OUTPUT_ACTIVE_STATE |-> !rxEnable;
  endproperty
  a_active_rx: assert property (p_active_rx) else $error("receiver on in output state");
  property p_restart;
    wakeCnt <= RESTART_CYCLES + 4;
  endproperty
  a_restart: assert property (p_restart) else $error("restart timer overran");
  property p_fault_int;
    $changed(faultPins) ##0 (!statusAccess)[*8] |-> intPin;
  endproperty
  a_fault_int: assert property (p_fault_int) else $error("fault change not flagged");
  property p_access_clear;
    statusAccess && quietCnt > 5 && !statusByte[`STAT_DATA_EVENT] && !rxIn.msgDone &&
      !rxIn.error |=> !intPin;
  endproperty
  a_access_clear: assert property (p_access_clear) else $error("int kept after access");
  property p_rx_reset;
    $rose(switchOutputModeBit) && rxIn.busy &&
      linkState == line_uart_pkg::COMM_LISTEN_STATE |-> ##[1:3] rxReset;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver not reset");
  property p_short;
    $rose(faultPins.shortCircuit) && linkState == line_uart_pkg::TRANSMIT_STATE |->
      ##[1:8] (statusByte[`STAT_SHORT] && linkState != line_uart_pkg::TRANSMIT_STATE);
  endproperty
  a_short: assert property (p_short) else $error("short not handled");
endmodule

bind line_uart_multi_octet_link_fsm line_link_checker #(.RESTART_CYCLES(RESTART_CYCLES)) chk_u (.*);
`default_nettype wire

// ==== bench/line_master_model.sv ====
/*
  Line master model: decoded message pulses and a paced line transmitter.
  Assumes the block's ref_clk; requests come from the testbench.
*/
`timescale 1ns/10ps
`default_nettype none

module line_master_model (
  input wire logic ref_clk,
  input wire logic startMsg,
  input wire logic msgErr,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txOctet,
  output var line_uart_pkg::rx_s rxIn,
  output logic txReady,
  output logic txIdle,
  output logic [7:0] txSig,
  output logic [7:0] txCount
);
  logic [2:0] step = 3'h0;
  logic [2:0] pace = 3'h0;
  initial
  begin
    rxIn = '0;
    txSig = 8'h00;
    txCount = 8'h00;
  end
  // --------
  // two-octet message, octet lines not held between octets
  // --------
  always @(posedge ref_clk)
  begin
    step <= startMsg ? 3'h1 : step + {2'h0, step != 3'h0};
    rxIn.busy <= step != 3'h0;
    rxIn.valid <= step == 3'h2 || step == 3'h4;
    rxIn.octet <= step == 3'h2 ? 8'hA5 : (step == 3'h4 ? 8'h3C : ~rxIn.octet);
    rxIn.msgDone <= step == 3'h6;
    rxIn.error <= step == 3'h6 && msgErr;
  end
  assign txReady = txValid && pace == 3'h0;
  assign txIdle = pace == 3'h0;
  always @(posedge ref_clk)
  begin
    if (txReady)
    begin
      pace <= slow ? 3'h7 : 3'h2;
      txSig <= {txSig[6:0], txSig[7]} ^ txOctet;
      txCount <= txCount + 8'h01;
    end
    else if (pace != 3'h0)
      pace <= pace - 3'h1;
  end
endmodule
`default_nettype wire

// ==== bench/line_uart_multi_octet_link_fsm_tb_top.sv ====
/*
  Testbench of the multi-octet link block: host and mode sequences.
  Assumes the line master model and a 100 MHz ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module line_uart_multi_octet_link_fsm_tb_top;
  localparam line_uart_pkg::link_state_e ST_ACT = line_uart_pkg::OUTPUT_ACTIVE_STATE;
  localparam line_uart_pkg::link_state_e ST_WAKE = line_uart_pkg::WAKEUP_LISTEN_STATE;
  localparam line_uart_pkg::link_state_e ST_COMM = line_uart_pkg::COMM_LISTEN_STATE;
  localparam line_uart_pkg::link_state_e ST_TX = line_uart_pkg::TRANSMIT_STATE;
  logic ref_clk = 1'b0;
  logic arst_n, switchOutputModeBit, highSideEnable, lowSideEnable, wakeupPin, statusAccess;
  logic cmdEnd, cmdSend, bufWrEn, txReady, txIdle, startMsg, msgErr, slow, lineHigh;
  logic lineLow, rxEnable, rxReset, intPin, txValid, restartRunning;
  logic [3:0] txLength, bufWrAddr, bufRdAddr;
  logic [7:0] bufWrData, statusByte, bufRdData, txOctet, txSig, txCount, expSig, baseCount;
  line_uart_pkg::fault_s faultPins;
  line_uart_pkg::rx_s rxIn;
  line_uart_pkg::link_state_e linkState;
  int miscompares = 0;
  int total_checks = 0;
  int i;
  always #5 ref_clk = ~ref_clk;
  line_uart_multi_octet_link_fsm #(.RESTART_CYCLES(50), .FIFO_DEPTH(4)) dut_u (.*);
  line_master_model master_u (.*);
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task waitState(input line_uart_pkg::link_state_e s);
    for (int n = 0; n < 300 && linkState !== s; n++)
      tick(1);
    check("linkState", 8'(linkState), 8'(s));
    if (linkState !== s)
      conclude();
  endtask
  task message(input logic err);
    msgErr <= err;
    startMsg <= 1'b1;
    tick(1);
    startMsg <= 1'b0;
    waitState(ST_TX);
  endtask
  task access;
    statusAccess <= 1'b1;
    tick(1);
    statusAccess <= 1'b0;
    tick(1);
  endtask
  task command(input logic send);
    cmdSend <= send;
    cmdEnd <= !send;
    tick(1);
    cmdSend <= 1'b0;
    cmdEnd <= 1'b0;
    tick(1);
    check("dataEvent", 8'(statusByte[0]), 8'h00);
  endtask
  initial
  begin
    {arst_n, switchOutputModeBit, highSideEnable, lowSideEnable, wakeupPin} = '0;
    {statusAccess, cmdEnd, cmdSend, bufWrEn, startMsg, msgErr, slow} = '0;
    faultPins = '0;
    {txLength, bufWrAddr, bufRdAddr, bufWrData} = '0;
    tick(10);
    arst_n <= 1'b1;
    tick(3);
    check("rxEnable", 8'(rxEnable), 8'h01);
    waitState(ST_COMM);
    message(1'b0);
    check("intPin", 8'(intPin), 8'h01);
    access();
    bufRdAddr <= 4'h1;
    tick(5);
    check("dataEvent", 8'(statusByte[0]), 8'h01);
    check("frame1", bufRdData, 8'h3C);
    expSig = 8'h00;
    for (i = 1; i <= 6; i++)
    begin
      bufWrEn <= 1'b1;
      bufWrAddr <= 4'(i - 1);
      bufWrData <= 8'(8'h31 * i);
      expSig = {expSig[6:0], expSig[7]} ^ 8'(8'h31 * i);
      tick(1);
    end
    bufWrEn <= 1'b0;
    bufRdAddr <= 4'h5;
    tick(3);
    check("frame5", bufRdData, 8'h26);
    baseCount = txCount;
    slow <= 1'b1;
    txLength <= 4'h6;
    command(1'b1);
    waitState(ST_COMM);
    check("txSig", txSig, expSig);
    check("txCount", txCount - baseCount, 8'h06);
    message(1'b1);
    check("rxError", 8'(statusByte[2]), 8'h01);
    access();
    command(1'b0);
    waitState(ST_COMM);
    message(1'b0);
    access();
    command(1'b1);
    tick(4);
    faultPins.shortCircuit <= 1'b1;
    waitState(ST_COMM);
    check("short", 8'(statusByte[3]), 8'h01);
    access();
    check("intPin", 8'(intPin), 8'h00);
    faultPins.shortCircuit <= 1'b0;
    tick(10);
    check("intPin", 8'(intPin), 8'h01);
    access();
    check("intPin", 8'(intPin), 8'h00);
    faultPins.underVoltage <= 1'b1;
    tick(10);
    check("intPin", 8'(intPin), 8'h01);
    check("underVolt", 8'(statusByte[4]), 8'h01);
    access();
    check("intPin", 8'(intPin), 8'h00);
    switchOutputModeBit <= 1'b1;
    highSideEnable <= 1'b1;
    waitState(ST_ACT);
    tick(2);
    check("drive", {6'h00, lineHigh, lineLow}, 8'h02);
    highSideEnable <= 1'b0;
    wakeupPin <= 1'b1;
    tick(10);
    check("state", 8'(linkState), 8'(ST_ACT));
    highSideEnable <= 1'b1;
    waitState(ST_WAKE);
    wakeupPin <= 1'b0;
    tick(2);
    check("drive", {6'h00, lineHigh, lineLow}, 8'h00);
    check("restart", 8'(restartRunning), 8'h01);
    waitState(ST_ACT);
    wakeupPin <= 1'b1;
    waitState(ST_WAKE);
    wakeupPin <= 1'b0;
    message(1'b0);
    switchOutputModeBit <= 1'b0;
    access();
    command(1'b0);
    waitState(ST_COMM);
    startMsg <= 1'b1;
    tick(1);
    startMsg <= 1'b0;
    tick(2);
    switchOutputModeBit <= 1'b1;
    for (i = 0; i < 6 && rxReset !== 1'b1; i++)
      tick(1);
    check("rxReset", 8'(rxReset), 8'h01);
    switchOutputModeBit <= 1'b0;
    waitState(ST_COMM);
    conclude();
  end
endmodule
`default_nettype wire
